//--- verilog/dsb_pkg.sv
// Shared constants of the strobe burst link: widths, phases and spacing.
// Assumes both ends and the link interface import it whole.
`default_nettype none

package dsb_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DQ_W    = 8;
	localparam int WORD_W  = 2 * DQ_W;
	localparam int BURST_W = 4 * DQ_W;
	localparam int ADDR_W  = 2;
	localparam int RANK_W  = 1;
	localparam int MEM_N   = 8;

	// ------------------------------------------------------------
	// Link clock made by the controller
	// ------------------------------------------------------------
	localparam int         CLK_NS   = 10;
	localparam int         CK_DIV   = 4;
	localparam int         CK_NS    = CLK_NS * CK_DIV;
	localparam logic [1:0] PH_ISSUE = 2'h3;

	// ------------------------------------------------------------
	// Controller schedule, in system clocks after issue
	// ------------------------------------------------------------
	localparam int WSH_LEN = 12;
	localparam int W_PRE   = 1;
	localparam int W_BEAT0 = 4;
	localparam int W_LAST  = 11;
	localparam int RSH_LEN = 18;
	localparam int R_BEAT0 = 11;
	localparam int R_LAST  = 17;

	// ------------------------------------------------------------
	// Command spacing, in link clocks
	// ------------------------------------------------------------
	localparam int WR_LAST_IN_HALF = 5;
	localparam int WR_RD_TURN_HALF = 3;
	localparam logic [2:0] GAP_WR_RD =
		3'((WR_LAST_IN_HALF + WR_RD_TURN_HALF) / 2);
	localparam logic [2:0] GAP_RD_SAME = 3'h2;
	localparam logic [2:0] GAP_RD_DIFF = 3'h3;
	localparam logic [2:0] GAP_WR_WR   = 3'h2;
	localparam logic [2:0] GAP_RD_WR   = 3'h5;
	localparam logic [2:0] SINCE_MAX   = 3'h7;

	// Byte k of a burst, beat 0 in the low bits.
	function automatic logic [DQ_W-1:0] byte_of(
		input logic [BURST_W-1:0] data,
		input int                 k
	);
		return data[k*DQ_W +: DQ_W];
	endfunction

endpackage

`default_nettype wire

//--- verilog/dsb_link_if.sv
// Link between controller and memory: clock, command and shared pins.
// Assumes one memory end and one controller end; resolves the wires.
`default_nettype none

interface dsb_link_if;
	import dsb_pkg::*;

	// ------------------------------------------------------------
	// Clock and command, driven by the controller
	// ------------------------------------------------------------
	logic              ck;
	logic              cmd_valid;
	logic              cmd_we;
	logic [RANK_W-1:0] cmd_rank;
	logic [ADDR_W-1:0] cmd_addr;

	// ------------------------------------------------------------
	// Two-way data and strobe pins
	// ------------------------------------------------------------
	logic [DQ_W-1:0] ctl_dq_o;
	logic            ctl_dq_oe;
	logic            ctl_dqs_o;
	logic            ctl_dqs_oe;
	logic [DQ_W-1:0] dev_dq_o;
	logic            dev_dq_oe;
	logic            dev_dqs_o;
	logic            dev_dqs_oe;
	wire  [DQ_W-1:0] dq;
	wire             dqs;

	// Released pins read high, so a missing preamble low is never masked.
	assign dq  = ctl_dq_oe ? ctl_dq_o : (dev_dq_oe ? dev_dq_o : 8'hFF);
	assign dqs = ctl_dqs_oe ? ctl_dqs_o : (dev_dqs_oe ? dev_dqs_o : 1'h1);

	modport ctl (
		output ck, cmd_valid, cmd_we, cmd_rank, cmd_addr,
		output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
		input  dq, dqs
	);

	modport dev (
		input  ck, cmd_valid, cmd_we, cmd_rank, cmd_addr,
		output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe,
		input  dq, dqs
	);

endinterface

`default_nettype wire

//--- verilog/dsb_mem_end.sv
// Memory end: answers reads and takes writes on the link clock.
// Assumes the controller keeps command spacing and strobe timing.
`default_nettype none

module dsb_mem_end
	import dsb_pkg::*;
#(
	parameter logic [RANK_W-1:0] RANK = 1'h0
) (
	input  wire logic arst_n,   // Asynchronous reset, active low.
	dsb_link_if.dev   lnk,      // Link pins.
	output logic      strb_err  // Write preamble strobe was not low.
);

	// ------------------------------------------------------------
	// Storage and pipelines
	// ------------------------------------------------------------
	logic [WORD_W-1:0] mem [MEM_N];
	logic [4:1]        rs;
	logic [ADDR_W-1:0] ra [4:1];
	logic [2:0]        ws;
	logic [ADDR_W-1:0] wa [2:0];
	logic [DQ_W-1:0]   ev;
	logic [DQ_W-1:0]   od;
	logic [DQ_W:0]     pos_q;
	logic [DQ_W:0]     neg_q;
	logic              pre_low;

	// Command decode for this rank.
	wire hit    = lnk.cmd_valid & (lnk.cmd_rank == RANK);
	wire rd_hit = hit & ~lnk.cmd_we;
	wire wr_hit = hit & lnk.cmd_we;

	// Words of the two halves of a burst.
	wire [WORD_W-1:0] w2_lo = mem[{ra[2], 1'b0}];
	wire [WORD_W-1:0] w3_hi = mem[{ra[3], 1'b1}];
	wire [WORD_W-1:0] w3_lo = mem[{ra[3], 1'b0}];
	wire [WORD_W-1:0] w4_hi = mem[{ra[4], 1'b1}];

	// edge aligned: strobe high with even beats, low with odd.
	wire [DQ_W:0] even = rs[2] ? {1'b1, w2_lo[DQ_W-1:0]} :
		rs[3] ? {1'b1, w3_hi[DQ_W-1:0]} : '0;
	wire [DQ_W:0] odd = rs[3] ? {1'b0, w3_lo[WORD_W-1:DQ_W]} :
		rs[4] ? {1'b0, w4_hi[WORD_W-1:DQ_W]} : '0;

	// Both edges: the pin value is the xor of the two halves.
	assign {lnk.dev_dqs_o, lnk.dev_dq_o} = pos_q ^ neg_q;
	// preamble drives low one clock before data.
	// postamble releases half a clock after the last edge.
	assign lnk.dev_dqs_oe = |rs[4:2];
	assign lnk.dev_dq_oe  = |rs[4:3];

	// ------------------------------------------------------------
	// Rising edge of the link clock
	// ------------------------------------------------------------
	// reads to this rank chain without a gap.
	always_ff @(posedge lnk.ck or negedge arst_n) begin
		if (!arst_n) begin
			rs    <= '0;
			ws    <= '0;
			pos_q <= '0;
		end else begin
			rs    <= {rs[3:1], rd_hit};
			ws    <= {ws[1:0], wr_hit};
			pos_q <= even ^ neg_q;
		end
	end

	// Addresses follow their commands down the pipelines.
	always_ff @(posedge lnk.ck) begin
		ra[1] <= lnk.cmd_addr;
		ra[2] <= ra[1];
		ra[3] <= ra[2];
		ra[4] <= ra[3];
		wa[0] <= lnk.cmd_addr;
		wa[1] <= wa[0];
		wa[2] <= wa[1];
	end

	// first even beat is taken one clock after the write.
	// a word is written once both of its beats are held.
	always_ff @(posedge lnk.ck) begin
		if (ws[0] | ws[1])
			ev <= lnk.dq;
		if (ws[1])
			mem[{wa[1], 1'b0}] <= {od, ev};
		if (ws[2])
			mem[{wa[2], 1'b1}] <= {od, ev};
	end

	// Flags a write whose strobe was not low at the first fall.
	always_ff @(posedge lnk.ck or negedge arst_n) begin
		if (!arst_n)
			strb_err <= 1'b0;
		else
			strb_err <= ws[1] & ~pre_low;
	end

	// ------------------------------------------------------------
	// Falling edge of the link clock
	// ------------------------------------------------------------
	// Odd beats go out and come in on the falling edge.
	always_ff @(negedge lnk.ck or negedge arst_n) begin
		if (!arst_n) begin
			neg_q   <= '0;
			pre_low <= 1'b1;
		end else begin
			neg_q <= odd ^ pos_q;
			// A chained write ends its last strobe low on this same edge.
			if (ws[0])
				pre_low <= ws[2] | (lnk.dqs == 1'b0);
		end
	end

	// Odd write beats are held for the next word.
	always_ff @(negedge lnk.ck) begin
		if (ws[1] | ws[2])
			od <= lnk.dq;
	end

endmodule

`default_nettype wire

//--- verilog/dsb_ctl_end.sv
// Controller end: makes the link clock, issues spaced commands,
// drives write bursts and captures read bursts.
// Assumes the link clock feeds the memory end only, so the read pins
// change on system clock edges and sit still between them.
`default_nettype none

//Contract
// - Reads to other ranks leave one clock gap.
// - Reads to the same rank may chain gaplessly.
// - First write strobe rise lands within window.
// - Second write beat arrives quarter clock early.
// - Memory writes a word after two beats.
// - Write latency one clock, zero to strobe.
// - Strobe low at fall after write command.
// - Read waits 1.5 clocks after last data-in.
// - Read data edges coincide with strobe edges.
// - Write strobe edges centred in data window.
// - Read strobe shifted a quarter period.
// - Beats 1,3 at 90, 4 at 270 degrees.
// - Read preamble drives strobe low one clock.
// - Read postamble releases half clock after.
// - Receiver enabled only across read window.
module dsb_ctl_end
	import dsb_pkg::*;
(
	input  wire logic               clk,        // System clock.
	input  wire logic               arst_n,     // Async reset, low.
	dsb_link_if.ctl                 lnk,        // Link pins.
	input  wire logic               req_valid,  // Request present.
	input  wire logic               req_we,     // Request is a write.
	input  wire logic [RANK_W-1:0]  req_rank,   // Target rank.
	input  wire logic [ADDR_W-1:0]  req_addr,   // Burst address.
	input  wire logic [BURST_W-1:0] req_wdata,  // Write burst data.
	output logic                    req_ready,  // Request taken now.
	output logic                    rsp_valid,  // Read data pulse.
	output logic [BURST_W-1:0]      rsp_rdata,  // Read burst data.
	output logic                    rsp_err     // Strobe level wrong.
);

	// ------------------------------------------------------------
	// Link clock divider
	// ------------------------------------------------------------
	logic [1:0] ph;
	logic       ck;
	wire  [1:0] next_ph = ph + 2'h1;
	wire        slot    = (ph == PH_ISSUE);

	// The link clock falls on the issue edge and rises two later.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ph <= '0;
			ck <= 1'b0;
		end else begin
			ph <= next_ph;
			ck <= next_ph[1];
		end
	end

	assign lnk.ck = ck;

	// ------------------------------------------------------------
	// Command spacing
	// ------------------------------------------------------------
	logic [2:0]        since;
	logic              last_we;
	logic [RANK_W-1:0] last_rank;

	// Link clocks needed between the last command and a new one.
	function automatic logic [2:0] gap_need(
		input logic prev_we,
		input logic we,
		input logic same
	);
		if (prev_we)
			return we ? GAP_WR_WR : GAP_WR_RD;
		if (we)
			return GAP_RD_WR;
		return same ? GAP_RD_SAME : GAP_RD_DIFF;
	endfunction

	// other rank needs three clocks, same rank two.
	// a read waits four clocks after a write command.
	wire [2:0] need  = gap_need(last_we, req_we, last_rank == req_rank);
	wire       issue = req_valid & req_ready;
	wire       issue_wr = issue & req_we;
	wire       issue_rd = issue & ~req_we;

	assign req_ready = slot & (since >= need);

	// Counts link clocks since the last command, saturating.
	// tracks the rank and kind of the last command.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			since     <= SINCE_MAX;
			last_we   <= 1'b0;
			last_rank <= '0;
		end else if (slot) begin
			if (issue) begin
				since     <= 3'h1;
				last_we   <= req_we;
				last_rank <= req_rank;
			end else if (since != SINCE_MAX) begin
				since <= since + 3'h1;
			end
		end
	end

	// A command stands for one whole link clock around its rise.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lnk.cmd_valid <= 1'b0;
			lnk.cmd_we    <= 1'b0;
			lnk.cmd_rank  <= '0;
			lnk.cmd_addr  <= '0;
		end else if (slot) begin
			lnk.cmd_valid <= issue;
			lnk.cmd_we    <= req_we;
			lnk.cmd_rank  <= req_rank;
			lnk.cmd_addr  <= req_addr;
		end
	end

	// ------------------------------------------------------------
	// Write burst
	// ------------------------------------------------------------
	logic [WSH_LEN-1:0] wsh;
	logic [BURST_W-1:0] wpend;
	logic [BURST_W-1:0] wact;

	// Beat windows, two system clocks each.
	wire wb0_first = wsh[W_BEAT0];
	wire wb0 = wsh[W_BEAT0+1];
	wire wb1 = |wsh[W_BEAT0+3:W_BEAT0+2];
	wire wb2 = |wsh[W_BEAT0+5:W_BEAT0+4];
	wire wb3 = |wsh[W_BEAT0+7:W_BEAT0+6];

	// data changes a quarter clock before each strobe edge.
	// so the second beat is settled well before its edge.
	wire [DQ_W-1:0] next_dq =
		wb0_first ? byte_of(wpend, 0) :
		wb0       ? byte_of(wact, 0) :
		wb1       ? byte_of(wact, 1) :
		wb2       ? byte_of(wact, 2) :
		wb3       ? byte_of(wact, 3) : '0;

	// first strobe rise meets the link clock one clock on.
	wire next_dqs = wsh[W_BEAT0+1] | wsh[W_BEAT0+2] |
		wsh[W_BEAT0+5] | wsh[W_BEAT0+6];
	// strobe driven low from half a clock after the command.
	wire next_dqs_oe = |wsh[W_LAST:W_PRE];
	wire next_dq_oe  = |wsh[W_LAST:W_BEAT0];

	// Write schedule shifts by one every system clock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wsh <= '0;
		else
			wsh <= {wsh[WSH_LEN-2:0], issue_wr};
	end

	// Holds the queued burst, then the one on the pins.
	always_ff @(posedge clk) begin
		if (issue_wr)
			wpend <= req_wdata;
		if (wb0_first)
			wact <= wpend;
	end

	// pins are registered; the first beat starts a quarter clock before the first strobe rise.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lnk.ctl_dq_o   <= '0;
			lnk.ctl_dq_oe  <= 1'b0;
			lnk.ctl_dqs_o  <= 1'b0;
			lnk.ctl_dqs_oe <= 1'b0;
		end else begin
			lnk.ctl_dq_o   <= next_dq;
			lnk.ctl_dq_oe  <= next_dq_oe;
			lnk.ctl_dqs_o  <= next_dqs;
			lnk.ctl_dqs_oe <= next_dqs_oe;
		end
	end

	// ------------------------------------------------------------
	// Read capture
	// ------------------------------------------------------------
	logic [RSH_LEN-1:0] rsh;
	logic [DQ_W-1:0]    cap_dq;
	logic               cap_dqs;
	logic [BURST_W-1:0] acc;
	logic               err_acc;
	logic [3:0]         rb;

	// Capture strobe for beat k, one clock after its mid point.
	assign rb = {rsh[R_BEAT0+6], rsh[R_BEAT0+4],
		rsh[R_BEAT0+2], rsh[R_BEAT0]};

	// even beats are held while the strobe is high.
	wire bad_hi = cap_dqs != 1'b1;
	wire bad_lo = cap_dqs != 1'b0;

	// Read schedule shifts by one every system clock.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rsh <= '0;
		else
			rsh <= {rsh[RSH_LEN-2:0], issue_rd};
	end

	// pins are sampled a quarter clock after each edge.
	always_ff @(posedge clk) begin
		cap_dq  <= lnk.dq;
		cap_dqs <= lnk.dqs;
	end

	// beats are only taken inside the read window.
	always_ff @(posedge clk) begin
		for (int k = 0; k < 4; k++) begin
			if (rb[k])
				acc[k*DQ_W +: DQ_W] <= cap_dq;
		end
	end

	// Strobe level check across the four beats.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			err_acc <= 1'b0;
		else if (rb[0])
			err_acc <= bad_hi;
		else if (rb[1])
			err_acc <= err_acc | bad_lo;
		else if (rb[2])
			err_acc <= err_acc | bad_hi;
	end

	// the fourth beat is taken at the 270 degree point.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			rsp_err   <= 1'b0;
		end else begin
			rsp_valid <= rb[3];
			if (rb[3]) begin
				rsp_rdata <= {cap_dq, acc[3*DQ_W-1:0]};
				rsp_err   <= err_acc | bad_lo;
			end
		end
	end

endmodule

`default_nettype wire

//--- tb/dsb_link_asserts.sv
// Checker of the strobe burst link: timing relations on the shared pins.
// Assumes the testbench wires it to the link interface beside both ends.
`default_nettype none

module dsb_link_asserts
	import dsb_pkg::*;
#(
	parameter logic [RANK_W-1:0] RANK = 1'h0
) (
	input  wire logic              clk,        // System clock.
	input  wire logic              arst_n,     // Async reset, low.
	input  wire logic              ck,         // Link clock.
	input  wire logic              cmd_valid,  // Command present.
	input  wire logic              cmd_we,     // Command is a write.
	input  wire logic [RANK_W-1:0] cmd_rank,   // Command rank.
	input  wire logic [DQ_W-1:0]   ctl_dq_o,   // Controller data.
	input  wire logic              ctl_dq_oe,  // Controller drives data.
	input  wire logic              ctl_dqs_oe, // Controller drives strobe.
	input  wire logic [DQ_W-1:0]   dev_dq_o,   // Memory data.
	input  wire logic              dev_dq_oe,  // Memory drives data.
	input  wire logic              dev_dqs_oe, // Memory drives strobe.
	input  wire logic              dqs         // Resolved strobe.
);
	// ------------------------------------------------------------
	// Command tracking
	// ------------------------------------------------------------
	logic              ck_q;
	logic [4:0]        since;
	logic              last_we;
	logic [RANK_W-1:0] last_rank;
	// A command is seen one clock after the edge that dropped the link clock.
	wire               iss = !ck && ck_q && cmd_valid;
	wire  [4:0]        next_since = iss ? 5'h01 :
		(since == 5'h1F ? since : since + 5'h01);

	// Clocks since the last command, and what that command was.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ck_q      <= 1'b0;
			since     <= 5'h1F;
			last_we   <= 1'b0;
			last_rank <= 1'h0;
		end else begin
			ck_q      <= ck;
			since     <= next_since;
			last_we   <= iss ? cmd_we : last_we;
			last_rank <= iss ? cmd_rank : last_rank;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_wr_pre;
		(ctl_dqs_oe && !dqs) [*4];
	endsequence

	sequence s_rd_pre;
		(dev_dqs_oe && !dqs && !dev_dq_oe) [*4];
	endsequence

	chk_wr_preamble: assert property (
		iss && cmd_we && !ctl_dqs_oe |-> ##2 s_wr_pre ##1 (ctl_dqs_oe && dqs))
		else $error("write strobe preamble or first rise misplaced");
	chk_wr_beats: assert property (
		iss && cmd_we |-> ##5 ctl_dq_oe [*8])
		else $error("write beats not driven in their window");
	chk_wr_centre: assert property (
		ctl_dq_oe && $changed(dqs) |-> $stable(ctl_dq_o))
		else $error("write data moved on a strobe edge");
	chk_rd_preamble: assert property (
		$rose(dev_dqs_oe) |-> s_rd_pre ##1 (dev_dq_oe && dqs))
		else $error("read strobe preamble wrong");
	chk_rd_latency: assert property (
		iss && !cmd_we && cmd_rank == RANK |->
			##6 dev_dqs_oe ##4 (dev_dq_oe && dqs))
		else $error("read burst late or early");
	chk_rd_postamble: assert property (
		$fell(dev_dq_oe) |-> !dev_dqs_oe && $past(dqs, 1) == 1'b0 &&
			$past(dqs, 2) == 1'b0)
		else $error("read strobe postamble wrong");
	chk_rd_edge: assert property (
		dev_dq_oe && $past(dev_dq_oe) && $changed(dev_dq_o) |-> $changed(dqs))
		else $error("read data edge without strobe edge");
	chk_one_driver: assert property (
		!(ctl_dqs_oe && dev_dqs_oe) && !(ctl_dq_oe && dev_dq_oe))
		else $error("both ends drive the pins");
	chk_rd_spacing: assert property (
		iss && !cmd_we && !last_we |->
			since >= ((cmd_rank == last_rank) ? 5'h08 : 5'h0C))
		else $error("reads spaced too closely");
	chk_wr_rd_turn: assert property (
		iss && !cmd_we && last_we |-> since >= 5'h10)
		else $error("read too soon after write");

endmodule

`default_nettype wire

//--- tb/testbench.sv
// Testbench: controller and memory ends joined, plus a faulty link.
// Assumes the design package, interface and both ends are compiled.
`default_nettype none

module testbench;
	import dsb_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic               clk = 1'b0;
	logic               arst_n;
	logic               req_valid;
	logic               req_we;
	logic [RANK_W-1:0]  req_rank;
	logic [ADDR_W-1:0]  req_addr;
	logic [BURST_W-1:0] req_wdata;
	logic               req_ready;
	logic               rsp_valid;
	logic [BURST_W-1:0] rsp_rdata;
	logic               rsp_err;
	logic               strb_err;
	logic               strb_err_b;
	logic               strb_any = 1'b0;
	int                 error_cnt = 0;
	int                 cmp_count = 0;
	int                 cyc = 0;
	int                 t_take = 0;
	int                 t_prev = 0;
	logic [BURST_W-1:0] model [4];
	int                 due_q [$];
	logic [BURST_W-1:0] exp_q [$];
	logic               chk_q [$];

	dsb_link_if lnk ();
	dsb_link_if lnk_b ();

	dsb_ctl_end i_dsb_ctl_end (.clk(clk), .arst_n(arst_n), .lnk(lnk),
		.req_valid(req_valid), .req_we(req_we), .req_rank(req_rank),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err));
	dsb_mem_end #(.RANK(1'h0)) i_dsb_mem_end (.arst_n(arst_n), .lnk(lnk),
		.strb_err(strb_err));
	dsb_mem_end #(.RANK(1'h0)) i_dsb_mem_end_b (.arst_n(arst_n),
		.lnk(lnk_b), .strb_err(strb_err_b));
	dsb_link_asserts #(.RANK(1'h0)) i_dsb_link_asserts (.clk(clk),
		.arst_n(arst_n), .ck(lnk.ck), .cmd_valid(lnk.cmd_valid),
		.cmd_we(lnk.cmd_we), .cmd_rank(lnk.cmd_rank),
		.ctl_dq_o(lnk.ctl_dq_o), .ctl_dq_oe(lnk.ctl_dq_oe),
		.ctl_dqs_oe(lnk.ctl_dqs_oe), .dev_dq_o(lnk.dev_dq_o),
		.dev_dq_oe(lnk.dev_dq_oe), .dev_dqs_oe(lnk.dev_dqs_oe),
		.dqs(lnk.dqs));

	// System clock and an edge counter.
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;
	always @(posedge lnk.ck) if (strb_err === 1'b1) strb_any <= 1'b1;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [BURST_W-1:0] seen,
		input logic [BURST_W-1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Holds a request until taken and books the answer it should bring.
	task automatic issue(input logic we, input logic [RANK_W-1:0] rk,
		input logic [ADDR_W-1:0] ad, input logic [BURST_W-1:0] wd);
		int n;
		req_we = we;
		req_rank = rk;
		req_addr = ad;
		req_wdata = wd;
		req_valid = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		if (req_ready !== 1'b1) begin
			error_cnt++;
			close_out();
		end
		t_prev = t_take;
		t_take = cyc + 1;
		if (we && rk == 1'h0) model[ad] = wd;
		if (!we) begin
			due_q.push_back(t_take + 18);
			exp_q.push_back(model[ad]);
			chk_q.push_back(rk == 1'h0);
		end
		#1;
	endtask

	task automatic wait_rsp();
		int n;
		req_valid = 1'b0;
		n = 0;
		while (due_q.size() != 0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (due_q.size() != 0) begin
			error_cnt++;
			close_out();
		end
		#1;
	endtask

	// Write command on the spare link with a chosen preamble level.
	task automatic bad_wr(input logic lvl, input logic exp);
		logic seen;
		seen = 1'b0;
		lnk_b.cmd_valid = 1'b1;
		lnk_b.cmd_we = 1'b1;
		lnk_b.ctl_dqs_oe = 1'b1;
		lnk_b.ctl_dqs_o = lvl;
		repeat (4) begin
			#6 lnk_b.ck = 1'b1;
			#1 seen = seen | (strb_err_b === 1'b1);
			#5 lnk_b.ck = 1'b0;
			lnk_b.cmd_valid = 1'b0;
		end
		lnk_b.ctl_dqs_oe = 1'b0;
		check(32'(seen), 32'(exp)); // preamble level.
	endtask

	// Each read answer: time; data and strobe level for rank 0 only.
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			check(32'(cyc), 32'(due_q[0])); // capture time.
			if (chk_q[0] === 1'b1) begin
				check(rsp_rdata, exp_q[0]); // read data.
				check(32'(rsp_err), 32'h0); // strobe level.
			end
			void'(due_q.pop_front());
			void'(exp_q.pop_front());
			void'(chk_q.pop_front());
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		req_valid = 1'b0;
		req_we = 1'b0;
		req_rank = 1'h0;
		req_addr = 2'h0;
		req_wdata = 32'h0;
		lnk_b.ck = 1'b0;
		lnk_b.cmd_valid = 1'b0;
		lnk_b.cmd_we = 1'b0;
		lnk_b.cmd_rank = 1'h0;
		lnk_b.cmd_addr = 2'h0;
		lnk_b.ctl_dq_o = 8'h00;
		lnk_b.ctl_dq_oe = 1'b0;
		lnk_b.ctl_dqs_o = 1'b0;
		lnk_b.ctl_dqs_oe = 1'b0;
		repeat (6) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		for (int a = 0; a < 4; a++) begin
			issue(1'b1, 1'h0, 2'(a), 32'hC3A5_5A3C ^ {4{8'(a * 8'h11)}});
		end
		$display("Test 1 done: back-to-back writes");
		for (int a = 0; a < 4; a++) begin
			issue(1'b0, 1'h0, 2'(a), 32'h0);
			if (a == 0) begin
				check(32'(t_take - t_prev), 32'h10); // write turnaround.
			end else begin
				check(32'(t_take - t_prev), 32'h8); // gapless reads.
			end
		end
		// The rank switch follows the last read at once, so its gap shows.
		$display("Test 2 done: gapless reads");
		issue(1'b0, 1'h1, 2'h0, 32'h0);
		check(32'(t_take - t_prev), 32'hC); // rank switch.
		issue(1'b0, 1'h0, 2'h1, 32'h0);
		check(32'(t_take - t_prev), 32'hC); // switch back.
		issue(1'b1, 1'h0, 2'h2, 32'h5A5A_F00F);
		issue(1'b0, 1'h0, 2'h2, 32'h0);
		check(32'(t_take - t_prev), 32'h10); // write recovery.
		wait_rsp();
		check(32'(strb_any), 32'h0); // good preambles.
		$display("Test 3 done: rank switch and turnaround");
		bad_wr(1'b1, 1'b1);
		bad_wr(1'b0, 1'b0);
		$display("Test 4 done: preamble fault");
		close_out();
	end

endmodule

`default_nettype wire
